// ===== cfce_pkg.sv
// cfce_pkg: register offsets, status word layout, branch test codes, carriers
// assumes: single pclk domain, APB with 32-bit data
package cfce_pkg;

	// ----------------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------------
	localparam logic [7:0] CFCE_STATUS_OFFSET = 8'hFC;
	localparam logic [7:0] CFCE_TEST_OFFSET   = 8'hF8;
	localparam logic [7:0] CFCE_STATUS_RESET  = 8'h00;

	// ----------------------------------------------------------------------
	// status word field positions
	// ----------------------------------------------------------------------
	localparam int CFCE_BIT_CARRY = 7;
	localparam int CFCE_BIT_ZERO  = 6;
	localparam int CFCE_BIT_SIGN  = 5;
	localparam int CFCE_BIT_OVFL  = 4;
	localparam int CFCE_BIT_DEC   = 3;
	localparam int CFCE_BIT_HALF  = 2;
	localparam int CFCE_BIT_USER1 = 1;
	localparam int CFCE_BIT_USER2 = 0;

	// ----------------------------------------------------------------------
	// types
	// ----------------------------------------------------------------------
	typedef enum logic [3:0] {
		CFCE_NEVER              = 4'h0,
		CFCE_SIGNED_BELOW       = 4'h1,
		CFCE_SIGNED_AT_MOST     = 4'h2,
		CFCE_UNSIGNED_AT_MOST   = 4'h3,
		CFCE_WRAP_SET           = 4'h4,
		CFCE_NEGATIVE_RESULT    = 4'h5,
		CFCE_SAME_VALUES        = 4'h6,
		CFCE_UNSIGNED_BELOW     = 4'h7,
		CFCE_ALWAYS             = 4'h8,
		CFCE_SIGNED_AT_LEAST    = 4'h9,
		CFCE_SIGNED_ABOVE       = 4'hA,
		CFCE_UNSIGNED_ABOVE     = 4'hB,
		CFCE_WRAP_CLEAR         = 4'hC,
		CFCE_POSITIVE_RESULT    = 4'hD,
		CFCE_RESULT_NOT_NULL    = 4'hE,
		CFCE_UNSIGNED_AT_LEAST  = 4'hF
	} cfce_test_t;

	typedef enum logic [2:0] {
		CFCE_OP_NONE   = 3'h0,
		CFCE_OP_ARITH  = 3'h1,
		CFCE_OP_LOGIC  = 3'h2,
		CFCE_OP_SHIFT  = 3'h3,
		CFCE_OP_DECADJ = 3'h4
	} cfce_op_t;

	typedef struct packed {
		logic carry;
		logic zero;
		logic sign;
		logic ovfl;
		logic dec;
		logic half;
		logic user1;
		logic user2;
	} cfce_flags_t;

	// one flag update from the alu, valid for one cycle
	typedef struct packed {
		logic       valid;
		cfce_op_t   op;
		logic [7:0] result;
		logic       carry_out;
		logic       half_out;
		logic       ovfl_out;
		logic       dec_in;
		logic       bit_out;
	} cfce_update_t;

endpackage

// ===== cfce_cond_eval.sv
// cfce_cond_eval: combinational branch test of a 4-bit code against the flags
// assumes: flags come from the registered status word of the same clock
`timescale 1ns/1ps
`default_nettype none
module cfce_cond_eval (
	input  wire logic                 [3:0] test_code,
	input  wire cfce_pkg::cfce_flags_t      flags,
	output logic                            take
);

	logic cz;
	logic sv;
	logic base;

	// only c, z, s and v steer the decision
	assign cz = flags.carry | flags.zero;
	assign sv = flags.sign ^ flags.ovfl;

	// bit 3 of the code inverts the low-half test
	always_comb begin
		unique case (test_code[2:0])
			3'h0: base = 1'b0;
			3'h1: base = sv;
			3'h2: base = flags.zero | sv;
			3'h3: base = cz;
			3'h4: base = flags.ovfl;
			3'h5: base = flags.sign;
			3'h6: base = flags.zero;
			3'h7: base = flags.carry;
		endcase
		take = base ^ test_code[3];
	end

endmodule
`default_nettype wire

// ===== cfce_top.sv
// cfce_top: cpu status word with apb access and branch condition evaluation
// assumes: alu drives one update per cycle on pclk; apb master on same clock
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cfce_top (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic           [7:0]  paddr,
	input  wire logic           [31:0] pwdata,
	input  wire logic           [3:0]  pstrb,
	output logic                [31:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	// alu flag update
	input  wire cfce_pkg::cfce_update_t upd,
	// branch test request from the sequencer
	input  wire logic                  br_req,
	input  wire logic           [3:0]  branch_test_code,
	output logic                       br_valid,
	output logic                       br_take,
	// status word seen by the core
	output var cfce_pkg::cfce_flags_t  flags_out
);

	// ----------------------------------------------------------------------
	// state
	// ----------------------------------------------------------------------
	cfce_pkg::cfce_flags_t flags_reg;
	cfce_pkg::cfce_flags_t flags_next;
	logic [31:0]           prdata_reg;
	logic [31:0]           prdata_next;
	logic                  pready_reg;
	logic                  pready_next;
	logic                  pslverr_reg;
	logic                  pslverr_next;
	logic                  br_valid_reg;
	logic                  br_valid_next;
	logic                  br_take_reg;
	logic                  br_take_next;
	logic [3:0]            test_code_reg;
	logic [3:0]            test_code_next;
	logic                  test_take_reg;
	logic                  test_take_next;

	logic                  br_eval;
	logic                  tst_eval;
	logic                  apb_setup;
	logic                  apb_access;
	logic                  hit_status;
	logic                  hit_test;
	logic                  sw_write;
	cfce_pkg::cfce_flags_t hw_flags;
	cfce_pkg::cfce_flags_t sw_flags;

	// ----------------------------------------------------------------------
	// condition evaluators
	// ----------------------------------------------------------------------
	// one for the sequencer, one so software can probe a code on the word
	cfce_cond_eval u_br_eval (
		.test_code (branch_test_code),
		.flags     (flags_reg),
		.take      (br_eval)
	);

	cfce_cond_eval u_tst_eval (
		.test_code (test_code_reg),
		.flags     (flags_reg),
		.take      (tst_eval)
	);

	// ----------------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------------
	assign apb_setup  = psel & ~penable;
	assign apb_access = psel & penable & pready_reg;
	assign hit_status = (paddr == cfce_pkg::CFCE_STATUS_OFFSET);
	assign hit_test   = (paddr == cfce_pkg::CFCE_TEST_OFFSET);
	assign sw_write   = apb_access & pwrite & hit_status & pstrb[0];

	// ----------------------------------------------------------------------
	// hardware flag update
	// ----------------------------------------------------------------------
	always_comb begin
		hw_flags = flags_reg;
		if (upd.valid) begin
			unique case (upd.op)
				cfce_pkg::CFCE_OP_ARITH: begin
					hw_flags.carry = upd.carry_out;
					hw_flags.zero  = (upd.result == 8'h00);
					hw_flags.sign  = upd.result[7];
					hw_flags.ovfl  = upd.ovfl_out;
					hw_flags.dec   = upd.dec_in;
					hw_flags.half  = upd.half_out;
				end
				cfce_pkg::CFCE_OP_LOGIC: begin
					// logic ops leave carry alone and clear overflow
					hw_flags.zero = (upd.result == 8'h00);
					hw_flags.sign = upd.result[7];
					hw_flags.ovfl = 1'b0;
				end
				cfce_pkg::CFCE_OP_SHIFT: begin
					hw_flags.carry = upd.bit_out;
					hw_flags.zero  = (upd.result == 8'h00);
					hw_flags.sign  = upd.result[7];
					hw_flags.ovfl  = upd.ovfl_out;
				end
				cfce_pkg::CFCE_OP_DECADJ: begin
					// decimal adjust reuses carry from the correction
					hw_flags.carry = upd.carry_out;
					hw_flags.zero  = (upd.result == 8'h00);
					hw_flags.sign  = upd.result[7];
				end
				default: begin
					hw_flags = flags_reg;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// status word register
	// ----------------------------------------------------------------------
	// user bits have no hardware writer at all
	assign sw_flags = cfce_pkg::cfce_flags_t'(pwdata[7:0]);

	always_comb begin
		// the writing instruction defines the final word
		if (sw_write) begin
			flags_next = sw_flags;
		end else begin
			flags_next = hw_flags;
		end
	end

	// ----------------------------------------------------------------------
	// test code probe register
	// ----------------------------------------------------------------------
	always_comb begin
		test_code_next = test_code_reg;
		test_take_next = tst_eval;
		if (apb_access & pwrite & hit_test & pstrb[0]) begin
			test_code_next = pwdata[3:0];
		end
	end

	// ----------------------------------------------------------------------
	// apb response
	// ----------------------------------------------------------------------
	// no wait state: pready rises in the first access cycle
	always_comb begin
		pready_next  = apb_setup;
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		if (apb_setup) begin
			prdata_next = 32'h0000_0000;
			if (hit_status) begin
				prdata_next[7:0] = flags_next;
			end else if (hit_test) begin
				prdata_next[3:0] = test_code_reg;
				prdata_next[8]   = test_take_reg;
			end else begin
				pslverr_next = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------------
	// branch decision
	// ----------------------------------------------------------------------
	always_comb begin
		br_valid_next = br_req;
		br_take_next  = br_req & br_eval;
	end

	// ----------------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg     <= cfce_pkg::cfce_flags_t'(cfce_pkg::CFCE_STATUS_RESET);
			prdata_reg    <= 32'h0000_0000;
			pready_reg    <= 1'b0;
			pslverr_reg   <= 1'b0;
			br_valid_reg  <= 1'b0;
			br_take_reg   <= 1'b0;
			test_code_reg <= 4'h0;
			test_take_reg <= 1'b0;
		end else begin
			flags_reg     <= flags_next;
			prdata_reg    <= prdata_next;
			pready_reg    <= pready_next;
			pslverr_reg   <= pslverr_next;
			br_valid_reg  <= br_valid_next;
			br_take_reg   <= br_take_next;
			test_code_reg <= test_code_next;
			test_take_reg <= test_take_next;
		end
	end

	assign prdata    = prdata_reg;
	assign pready    = pready_reg;
	assign pslverr   = pslverr_reg;
	assign br_valid  = br_valid_reg;
	assign br_take   = br_take_reg;
	assign flags_out = flags_reg;

endmodule
`default_nettype wire

// ===== cfce_properties.sv
// cfce_properties: port checks for cfce_top, bound below
// assumes: one pclk domain, apb answers in the first access cycle
`timescale 1ns/1ps
`default_nettype none
module cfce_properties (
	input wire logic			pclk,
	input wire logic			presetn,
	input wire logic			psel,
	input wire logic			penable,
	input wire logic			pwrite,
	input wire logic [7:0]			paddr,
	input wire logic [31:0]			pwdata,
	input wire logic [3:0]			pstrb,
	input wire logic			pready,
	input wire cfce_pkg::cfce_update_t	upd,
	input wire logic			br_req,
	input wire logic [3:0]			branch_test_code,
	input wire logic			br_valid,
	input wire logic			br_take,
	input wire cfce_pkg::cfce_flags_t	flags_out
);
	logic sw_wr;
	logic alu_upd;
	// an update that a same-cycle write does not override
	assign sw_wr = psel && penable && pready && pwrite && pstrb[0]
		&& paddr == cfce_pkg::CFCE_STATUS_OFFSET;
	assign alu_upd = upd.valid && !sw_wr;

	// --------------
	// properties
	// --------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence arith_upd;
		alu_upd && upd.op == cfce_pkg::CFCE_OP_ARITH;
	endsequence

	ready_after_setup_a: assert property (apb_setup |=> pready)
		else $error("no ready in first access cycle");
	write_load_a: assert property (
		sw_wr |=> flags_out == $past(pwdata[7:0]))
		else $error("status write not loaded");
	arith_flags_a: assert property (arith_upd |=>
		flags_out.carry == $past(upd.carry_out)
		&& flags_out.half == $past(upd.half_out)
		&& flags_out.ovfl == $past(upd.ovfl_out))
		else $error("arith carry, half or overflow wrong");
	shift_carry_a: assert property (alu_upd
		&& upd.op == cfce_pkg::CFCE_OP_SHIFT
		|=> flags_out.carry == $past(upd.bit_out))
		else $error("shift carry not the bit moved out");
	arith_zero_a: assert property (arith_upd |=>
		flags_out.zero == ($past(upd.result) == 8'h00))
		else $error("zero flag wrong");
	sign_copy_a: assert property (alu_upd
		&& upd.op != cfce_pkg::CFCE_OP_NONE
		|=> flags_out.sign == $past(upd.result[7]))
		else $error("sign flag not result msb");
	user_hold_a: assert property (!sw_wr |=> $stable(flags_out[1:0]))
		else $error("user bits changed without a write");
	branch_reply_a: assert property (br_req |=> br_valid)
		else $error("no branch answer");
	never_always_a: assert property (
		br_req && branch_test_code[2:0] == 3'h0
		|=> br_take == $past(branch_test_code[3]))
		else $error("fixed branch code wrong");
	carry_branch_a: assert property (
		br_req && branch_test_code == 4'h7
		|=> br_take == $past(flags_out.carry))
		else $error("carry branch test wrong");
endmodule

bind cfce_top cfce_properties u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .pready, .upd, .br_req,
	.branch_test_code, .br_valid, .br_take, .flags_out);
`default_nettype wire

// ===== cfce_alu_model.sv
// cfce_alu_model: alu side handing one flag update per call
// assumes: caller sets valid; same pclk as the status word
`timescale 1ns/1ps
`default_nettype none
module cfce_alu_model (
	input  wire logic		pclk,
	output var cfce_pkg::cfce_update_t	upd
);
	initial upd = '0;
	// released fields turn inverted so stale data is never mistaken
	task automatic send(input cfce_pkg::cfce_update_t u);
		cfce_pkg::cfce_update_t idle;
		idle = ~u;
		idle.valid = 1'h0;
		@(posedge pclk);
		upd <= u;
		@(posedge pclk);
		upd <= idle;
	endtask
endmodule
`default_nettype wire

// ===== tb_cpu_flags_condition_eval.sv
// tb_cpu_flags_condition_eval: register, flag update and branch tests
// assumes: cfce_top and cfce_alu_model compiled with cfce_pkg
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_flags_condition_eval;
	logic			pclk = 1'h0;
	logic			presetn = 1'h0;
	logic			psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic			br_req = 1'h0, pready, pslverr, br_valid, br_take;
	logic [7:0]		paddr = 8'h00;
	logic [31:0]		pwdata = 32'h0, prdata, rd;
	logic [3:0]		pstrb = 4'h0, branch_test_code = 4'h0;
	logic			err;
	cfce_pkg::cfce_update_t	upd;
	cfce_pkg::cfce_flags_t	flags_out;
	int			err_total = 0, samples_checked = 0;

	always #20 pclk = ~pclk;
	cfce_alu_model alu (.pclk, .upd);
	cfce_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .upd, .br_req,
		.branch_test_code, .br_valid, .br_take, .flags_out);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'h1;
		// only the watchdog ends a wait that never sees ready
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic upd_chk(input cfce_pkg::cfce_op_t op,
			input logic [7:0] res, input logic [4:0] b,
			input logic [7:0] exp);
		alu.send({1'h1, op, res, b});
		#1;
		chk({24'h0, flags_out}, {24'h0, exp});
	endtask

	function automatic logic flag_test(input logic [3:0] c,
			input logic [7:0] f);
		logic sv;
		logic r;
		sv = f[5] ^ f[4];
		case (c[2:0])
			3'h0: r = 1'h0;
			3'h1: r = sv;
			3'h2: r = f[6] | sv;
			3'h3: r = f[7] | f[6];
			3'h4: r = f[4];
			3'h5: r = f[5];
			3'h6: r = f[6];
			default: r = f[7];
		endcase
		return r ^ c[3];
	endfunction

	task automatic br(input logic [3:0] c, input logic exp);
		@(posedge pclk);
		br_req <= 1'h1;
		branch_test_code <= c;
		@(posedge pclk);
		br_req <= 1'h0;
		#1;
		chk({30'h0, br_valid, br_take}, {30'h0, 1'h1, exp});
	endtask

	// --------------
	// tests
	// --------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 8'hFC, 32'h0, 4'h0);
		chk(rd, 32'h0);
		apb(1'h1, 8'hFC, 32'hFFFFFF5A, 4'hF);
		apb(1'h1, 8'hFC, 32'hA5, 4'hE);
		apb(1'h0, 8'hFC, 32'h0, 4'h0);
		chk(rd, 32'h5A);
		apb(1'h1, 8'h10, 32'hFF, 4'hF);
		apb(1'h0, 8'h10, 32'h0, 4'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		apb(1'h1, 8'hFC, 32'h03, 4'h1);
		upd_chk(cfce_pkg::CFCE_OP_ARITH, 8'h00, 5'h1E, 8'hDF);
		upd_chk(cfce_pkg::CFCE_OP_ARITH, 8'h80, 5'h00, 8'h23);
		upd_chk(cfce_pkg::CFCE_OP_SHIFT, 8'h01, 5'h01, 8'h83);
		upd_chk(cfce_pkg::CFCE_OP_LOGIC, 8'h00, 5'h00, 8'hC3);
		upd_chk(cfce_pkg::CFCE_OP_NONE, 8'hFF, 5'h1F, 8'hC3);
		upd_chk(cfce_pkg::CFCE_OP_DECADJ, 8'h99, 5'h10, 8'hA3);
		fork
			apb(1'h1, 8'hFC, 32'h3C, 4'h1);
			begin
				@(posedge pclk);
				alu.send({1'h1, cfce_pkg::CFCE_OP_ARITH, 8'h00, 5'h1F});
			end
		join
		#1;
		chk({24'h0, flags_out}, 32'h0000003C);
		// low nibble inverted so user, decimal and half bits vary too
		for (int n = 0; n < 16; n++) begin
			apb(1'h1, 8'hFC, {24'h0, n[3:0], ~n[3:0]}, 4'h1);
			for (int c = 0; c < 16; c++)
				br(c[3:0], flag_test(c[3:0], {n[3:0], ~n[3:0]}));
		end
		@(posedge pclk);
		#1;
		chk({30'h0, br_valid, br_take}, 32'h0);
		report_and_stop;
	end

	initial begin
		#200000;
		err_total++;
		report_and_stop;
	end
endmodule
`default_nettype wire
